// ---- rtl/aotr_pkg.sv ----
// package: register map, field layout and reset values of the offset trim register block
package aotr_pkg;
    // printed offsets (0x097 is not word aligned, so all are indices)
    localparam logic [11:0] IDX_TRIM_CORE1_IN_B = 12'h090;
    localparam logic [11:0] IDX_TRIM_CORE2_IN_A = 12'h092;
    localparam logic [11:0] IDX_TRIM_CORE2_IN_B = 12'h094;
    localparam logic [11:0] IDX_OFFSET_FILTER_CTRL_ZERO = 12'h097;
    localparam logic [11:0] IDX_CAL_CTRL = 12'h0a0;
    localparam logic [11:0] IDX_CAL_STATUS = 12'h0a1;
    localparam logic [11:0] IDX_ACCESS_STATUS = 12'h0a2;
    localparam int ADDR_W = 14;
    localparam int TRIM_W = 12;
    localparam int TRIM_REG_W = 16;
    localparam int FILT_REG_W = 8;
    // calibration control fields
    localparam int CC_BG_BIT = 0;
    localparam int CC_BGOS_BIT = 1;
    localparam int CC_OS_BIT = 2;
    localparam int CC_OSFILT_BIT = 3;
    localparam int CC_FG_START_BIT = 4;
    // calibration status fields
    localparam int CS_FG_BUSY_BIT = 0;
    localparam int CS_FOREGROUND_CAL_COMPLETE_BIT = 1;
    localparam int CS_HALTED_BIT = 2;
    localparam int FILT_KEEP_DC_BIT = 0;
    localparam logic [7:0] FILT_CTRL_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // write port shared between the bus slave and the register store
    typedef struct packed {
        logic valid;
        logic [11:0] index;
        logic [31:0] data;
        logic [3:0] strb;
    } aotr_wr_t;
endpackage

// ---- rtl/aotr_regs_if.sv ----
// interface: write and read paths between the bus slave and the register store
`timescale 1ns/10ps
interface aotr_regs_if;
    import aotr_pkg::*;
    aotr_wr_t wr;
    logic [11:0] rd_index;
    logic [31:0] rd_data;
    logic rd_hit;
    modport slave (output wr, output rd_index, input rd_data, input rd_hit);
    modport store (input wr, input rd_index, output rd_data, output rd_hit);
endinterface

// ---- rtl/aotr_store.sv ----
// register store: trim words, filter control and calibration control
`timescale 1ns/10ps
module aotr_store
    import aotr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register access
    aotr_regs_if.store regs,
    // factory trim values captured after reset
    input wire logic [TRIM_REG_W-1:0] fuse_c1b,
    input wire logic [TRIM_REG_W-1:0] fuse_c2a,
    input wire logic [TRIM_REG_W-1:0] fuse_c2b,
    input wire logic load_fuse,
    // register contents
    output logic [TRIM_REG_W-1:0] trim_c1b,
    output logic [TRIM_REG_W-1:0] trim_c2a,
    output logic [TRIM_REG_W-1:0] trim_c2b,
    output logic [FILT_REG_W-1:0] filt_ctrl,
    output logic [7:0] cal_ctrl
);
    // merge byte lanes of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction

    wire logic w_c1b = regs.wr.valid && regs.wr.index == IDX_TRIM_CORE1_IN_B;
    wire logic w_c2a = regs.wr.valid && regs.wr.index == IDX_TRIM_CORE2_IN_A;
    wire logic w_c2b = regs.wr.valid && regs.wr.index == IDX_TRIM_CORE2_IN_B;
    wire logic w_flt = regs.wr.valid && regs.wr.index == IDX_OFFSET_FILTER_CTRL_ZERO;
    wire logic w_cc = regs.wr.valid && regs.wr.index == IDX_CAL_CTRL;
    wire logic [31:0] m_c1b = merge({16'h0000, trim_c1b}, regs.wr.data, regs.wr.strb);
    wire logic [31:0] m_c2a = merge({16'h0000, trim_c2a}, regs.wr.data, regs.wr.strb);
    wire logic [31:0] m_c2b = merge({16'h0000, trim_c2b}, regs.wr.data, regs.wr.strb);
    wire logic [31:0] m_flt = merge({24'h000000, filt_ctrl}, regs.wr.data, regs.wr.strb);
    wire logic [31:0] m_cc = merge({24'h000000, cal_ctrl}, regs.wr.data, regs.wr.strb);

    // trim words: factory value after reset, then software may overwrite
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trim_c1b <= 16'h0000;
            trim_c2a <= 16'h0000;
            trim_c2b <= 16'h0000;
        end
        else if (load_fuse)
        begin
            trim_c1b <= fuse_c1b;
            trim_c2a <= fuse_c2a;
            trim_c2b <= fuse_c2b;
        end
        else
        begin
            // all 16 bits, upper four included, are stored and returned; bits 31:16 are dropped
            if (w_c1b)
                trim_c1b <= m_c1b[TRIM_REG_W-1:0];
            if (w_c2a)
                trim_c2a <= m_c2a[TRIM_REG_W-1:0];
            if (w_c2b)
                trim_c2b <= m_c2b[TRIM_REG_W-1:0];
        end
    end

    // filter control and calibration control
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            filt_ctrl <= FILT_CTRL_RESET;
            cal_ctrl <= 8'h00;
        end
        else
        begin
            if (w_flt)
                filt_ctrl <= m_flt[FILT_REG_W-1:0];
            if (w_cc)
                cal_ctrl <= m_cc[7:0];
        end
    end

    // read decode
    assign regs.rd_hit = regs.rd_index == IDX_TRIM_CORE1_IN_B ||
                         regs.rd_index == IDX_TRIM_CORE2_IN_A ||
                         regs.rd_index == IDX_TRIM_CORE2_IN_B ||
                         regs.rd_index == IDX_OFFSET_FILTER_CTRL_ZERO ||
                         regs.rd_index == IDX_CAL_CTRL;
    assign regs.rd_data = (regs.rd_index == IDX_TRIM_CORE1_IN_B) ? {16'h0000, trim_c1b} :
                          (regs.rd_index == IDX_TRIM_CORE2_IN_A) ? {16'h0000, trim_c2a} :
                          (regs.rd_index == IDX_TRIM_CORE2_IN_B) ? {16'h0000, trim_c2b} :
                          (regs.rd_index == IDX_OFFSET_FILTER_CTRL_ZERO) ?
                              {24'h000000, filt_ctrl} :
                          (regs.rd_index == IDX_CAL_CTRL) ? {24'h000000, cal_ctrl} :
                          32'h00000000;
endmodule

// ---- rtl/aotr_top.sv ----
// top: offset trim registers behind an AXI4-Lite slave, with trim selection per core
// Behaviour
// - core 1 sampling input B uses the 12-bit trim word held in the low bits at 0x090.
// - core 2 sampling input A uses its own 12-bit trim word at 0x092.
// - core 2 sampling input B uses its own 12-bit trim word at 0x094.
// - each trim word is an unsigned quantity and is extended with zeros, never sign.
// - after reset each trim word holds its factory value, readable and writable.
// - filter control bit 0 set removes only bank mismatch, clear removes all DC.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module aotr_top
    import aotr_pkg::*;
#(
    parameter logic [15:0] FUSE_CORE1_IN_B = 16'h0800,
    parameter logic [15:0] FUSE_CORE2_IN_A = 16'h0800,
    parameter logic [15:0] FUSE_CORE2_IN_B = 16'h0800
)
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RESET_I,
    // axi4-lite write address and data
    input wire logic [aotr_pkg::ADDR_W-1:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    // axi4-lite write response
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    // axi4-lite read
    input wire logic [aotr_pkg::ADDR_W-1:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    // calibration engine status (own clock domain assumed unknown, so synchronised)
    input wire logic FG_CAL_BUSY_I,
    input wire logic FOREGROUND_CAL_COMPLETE_I,
    input wire logic CALIBRATION_HALTED_I,
    // converter core sampling selects
    input wire logic CORE1_SAMPLES_B_I,
    input wire logic CORE2_SAMPLES_B_I,
    // trim applied to the converter cores
    output logic [aotr_pkg::TRIM_W-1:0] CORE1_TRIM_O,
    output logic [aotr_pkg::TRIM_W-1:0] CORE2_TRIM_O,
    output logic CORE1_TRIM_VALID_O,
    output logic CORE2_TRIM_VALID_O,
    // offset filter and calibration controls
    output logic KEEP_NEAR_DC_CONTENT_O,
    output logic OFFSET_FILTER_ENABLE_O,
    output logic BACKGROUND_CALIBRATION_ENABLE_O,
    output logic BACKGROUND_OFFSET_CAL_ENABLE_O,
    output logic OFFSET_CALIBRATION_ENABLE_O,
    output logic FG_CAL_START_O
);
    aotr_regs_if regs ();

    logic [TRIM_REG_W-1:0] trim_c1b;
    logic [TRIM_REG_W-1:0] trim_c2a;
    logic [TRIM_REG_W-1:0] trim_c2b;
    logic [FILT_REG_W-1:0] filt_ctrl;
    logic [7:0] cal_ctrl;
    logic load_fuse;
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_busy_err;
    logic rd_early_err;
    logic blocked;

    // core 1 input B and core 2 input A/B share this block; core 1 input A lives elsewhere
    aotr_store u_store (
        .clk(MCLK_I),
        .rst(RESET_I),
        .regs(regs.store),
        .fuse_c1b(FUSE_CORE1_IN_B),
        .fuse_c2a(FUSE_CORE2_IN_A),
        .fuse_c2b(FUSE_CORE2_IN_B),
        .load_fuse(load_fuse),
        .trim_c1b(trim_c1b),
        .trim_c2a(trim_c2a),
        .trim_c2b(trim_c2b),
        .filt_ctrl(filt_ctrl),
        .cal_ctrl(cal_ctrl)
    );

    // two-flop synchronisers for the calibration engine status and sample selects
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end
        else
        begin
            sync_a <= {CORE2_SAMPLES_B_I, CORE1_SAMPLES_B_I, CALIBRATION_HALTED_I,
                       FOREGROUND_CAL_COMPLETE_I, FG_CAL_BUSY_I};
            sync_b <= sync_a;
        end
    end
    wire logic fg_busy = sync_b[0];
    wire logic foreground_cal_complete = sync_b[1];
    wire logic halted = sync_b[2];
    wire logic c1_b = sync_b[3];
    wire logic c2_b = sync_b[4];

    // factory values loaded on the first cycle after reset release
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
            load_fuse <= 1'b1;
        else
            load_fuse <= 1'b0;
    end

    wire logic bg = cal_ctrl[CC_BG_BIT];
    wire logic bgos = cal_ctrl[CC_BGOS_BIT];
    wire logic os = cal_ctrl[CC_OS_BIT];
    function automatic logic is_trim(input logic [11:0] idx);
        return idx == IDX_TRIM_CORE1_IN_B || idx == IDX_TRIM_CORE2_IN_A ||
               idx == IDX_TRIM_CORE2_IN_B;
    endfunction

    // write channel: accept address and data in either order
    wire logic [11:0] w_index = aw_addr[ADDR_W-1:2];
    wire logic w_fire = have_aw && have_w && !BVALID_O;
    // decoded from the write index alone; the read decode follows the read address
    wire logic w_mapped = w_store_hit || w_index == IDX_CAL_STATUS ||
                          w_index == IDX_ACCESS_STATUS;
    wire logic w_store_hit = w_index != IDX_CAL_STATUS && w_index != IDX_ACCESS_STATUS &&
                             (w_index == IDX_TRIM_CORE1_IN_B || w_index == IDX_TRIM_CORE2_IN_A ||
                              w_index == IDX_TRIM_CORE2_IN_B || w_index == IDX_CAL_CTRL ||
                              w_index == IDX_OFFSET_FILTER_CTRL_ZERO);
    // trim writes refused while a calibration could overwrite or is reading them
    wire logic w_trim_locked = is_trim(w_index) && (fg_busy || (bg && bgos));
    assign regs.wr.valid = w_fire && w_store_hit && !w_trim_locked;
    assign regs.wr.index = w_index;
    assign regs.wr.data = w_data;
    assign regs.wr.strb = w_strb;

    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            BVALID_O <= 1'b0;
            BRESP_O <= RESP_OKAY;
        end
        else
        begin
            if (AWVALID_I && AWREADY_O)
                aw_addr <= AWADDR_I;
            if (WVALID_I && WREADY_O)
            begin
                w_data <= WDATA_I;
                w_strb <= WSTRB_I;
            end
            have_aw <= (have_aw || (AWVALID_I && AWREADY_O)) && !w_fire;
            have_w <= (have_w || (WVALID_I && WREADY_O)) && !w_fire;
            if (w_fire)
            begin
                BVALID_O <= 1'b1;
                BRESP_O <= (!w_mapped || w_trim_locked) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (BREADY_I)
                BVALID_O <= 1'b0;
        end
    end
    assign AWREADY_O = !have_aw && !BVALID_O;
    assign WREADY_O = !have_w && !BVALID_O;

    // read channel: one cycle answer, trims are flagged while not yet settled
    wire logic [11:0] r_index = ARADDR_I[ADDR_W-1:2];
    wire logic r_fire = ARVALID_I && ARREADY_O;
    wire logic r_early = is_trim(r_index) &&
                         ((os && !bgos && !foreground_cal_complete) || (bg && bgos && !halted));
    wire logic [31:0] status_word = {29'h0, halted, foreground_cal_complete, fg_busy};
    wire logic [31:0] access_word = {29'h0, rd_early_err, wr_busy_err, blocked};
    assign regs.rd_index = r_index;
    assign ARREADY_O = !RVALID_O;

    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h00000000;
            RRESP_O <= RESP_OKAY;
        end
        else if (r_fire)
        begin
            RVALID_O <= 1'b1;
            RDATA_O <= (r_index == IDX_CAL_STATUS) ? status_word :
                       (r_index == IDX_ACCESS_STATUS) ? access_word : regs.rd_data;
            RRESP_O <= (regs.rd_hit || r_index == IDX_CAL_STATUS ||
                        r_index == IDX_ACCESS_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (RREADY_I)
            RVALID_O <= 1'b0;
    end

    // access flags: the two error flags are sticky, set wins over the clear written to the access status word; blocked is live
    wire logic acc_clr = w_fire && w_index == IDX_ACCESS_STATUS;
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            wr_busy_err <= 1'b0;
            rd_early_err <= 1'b0;
            blocked <= 1'b0;
        end
        else
        begin
            wr_busy_err <= (w_fire && w_trim_locked) || (wr_busy_err && !acc_clr);
            rd_early_err <= (r_fire && r_early) || (rd_early_err && !acc_clr);
            blocked <= fg_busy || (bg && bgos);
        end
    end

    // trim selection per core and input, low 12 bits of each trim word taken as unsigned
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            CORE1_TRIM_O <= '0;
            CORE2_TRIM_O <= '0;
            CORE1_TRIM_VALID_O <= 1'b0;
            CORE2_TRIM_VALID_O <= 1'b0;
        end
        else
        begin
            CORE1_TRIM_O <= trim_c1b[TRIM_W-1:0];
            CORE1_TRIM_VALID_O <= c1_b;
            CORE2_TRIM_O <= c2_b ? trim_c2b[TRIM_W-1:0] : trim_c2a[TRIM_W-1:0];
            CORE2_TRIM_VALID_O <= !load_fuse;
        end
    end

    // control bits handed to the filter and calibration engine
    always_ff @(posedge MCLK_I)
    begin
        if (RESET_I)
        begin
            KEEP_NEAR_DC_CONTENT_O <= 1'b0;
            OFFSET_FILTER_ENABLE_O <= 1'b0;
            BACKGROUND_CALIBRATION_ENABLE_O <= 1'b0;
            BACKGROUND_OFFSET_CAL_ENABLE_O <= 1'b0;
            OFFSET_CALIBRATION_ENABLE_O <= 1'b0;
            FG_CAL_START_O <= 1'b0;
        end
        else
        begin
            KEEP_NEAR_DC_CONTENT_O <= filt_ctrl[FILT_KEEP_DC_BIT];
            OFFSET_FILTER_ENABLE_O <= cal_ctrl[CC_OSFILT_BIT];
            BACKGROUND_CALIBRATION_ENABLE_O <= bg;
            BACKGROUND_OFFSET_CAL_ENABLE_O <= bgos;
            OFFSET_CALIBRATION_ENABLE_O <= os;
            FG_CAL_START_O <= cal_ctrl[CC_FG_START_BIT];
        end
    end
endmodule

// ---- sim/aotr_properties.sv ----
// checker: bus handshake and register-map properties of the offset trim block
`timescale 1ns/10ps
module aotr_properties
    import aotr_pkg::*;
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RESET_I,
    // write channels
    input wire logic AWVALID_I,
    input wire logic AWREADY_O,
    input wire logic WVALID_I,
    input wire logic WREADY_O,
    input wire logic [1:0] BRESP_O,
    input wire logic BVALID_O,
    input wire logic BREADY_I,
    // read channels
    input wire logic [ADDR_W-1:0] ARADDR_I,
    input wire logic ARVALID_I,
    input wire logic ARREADY_O,
    input wire logic [31:0] RDATA_O,
    input wire logic [1:0] RRESP_O,
    input wire logic RVALID_O,
    input wire logic RREADY_I,
    // core select
    input wire logic CORE1_SAMPLES_B_I,
    input wire logic CORE1_TRIM_VALID_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    logic [11:0] rd_idx;
    // decode the index of the read under way; only meaningful while a read answer stands
    wire logic rd_trim = (rd_idx == IDX_TRIM_CORE1_IN_B) || (rd_idx == IDX_TRIM_CORE2_IN_A)
        || (rd_idx == IDX_TRIM_CORE2_IN_B);
    wire logic rd_map = rd_trim || (rd_idx == IDX_OFFSET_FILTER_CTRL_ZERO)
        || (rd_idx == IDX_CAL_CTRL) || (rd_idx == IDX_CAL_STATUS) || (rd_idx == IDX_ACCESS_STATUS);
    // remember the read index when the address is taken
    always_ff @(posedge MCLK_I)
    begin
        if (ARVALID_I && ARREADY_O)
        begin
            rd_idx <= ARADDR_I[13:2];
        end
    end
    property p_b_hold;
        BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
    property p_ar_answer;
        ARVALID_I && ARREADY_O |=> RVALID_O;
    endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
    property p_w_answer;
        AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##[1:4] BVALID_O;
    endproperty
    a_w_answer: assert property (p_w_answer) else $error("write not answered");
    property p_no_aw_busy;
        BVALID_O |-> !AWREADY_O;
    endproperty
    a_no_aw_busy: assert property (p_no_aw_busy) else $error("address taken with b");
    property p_no_ar_busy;
        RVALID_O |-> !ARREADY_O;
    endproperty
    a_no_ar_busy: assert property (p_no_ar_busy) else $error("address taken with r");
    property p_trim_upper;
        RVALID_O && rd_trim |-> RDATA_O[31:16] == 16'h0000 && RRESP_O == RESP_OKAY;
    endproperty
    a_trim_upper: assert property (p_trim_upper) else $error("trim read malformed");
    property p_unmapped;
        RVALID_O && !rd_map |-> RRESP_O == RESP_SLVERR && RDATA_O == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
    property p_core1_on;
        CORE1_SAMPLES_B_I [*4] |-> CORE1_TRIM_VALID_O;
    endproperty
    a_core1_on: assert property (p_core1_on) else $error("core1 trim not applied");
    property p_core1_off;
        !CORE1_SAMPLES_B_I [*4] |-> !CORE1_TRIM_VALID_O;
    endproperty
    a_core1_off: assert property (p_core1_off) else $error("core1 trim applied");
    c_write: cover property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O);
    c_trim_read: cover property (RVALID_O && rd_trim);
    c_bad_read: cover property (RVALID_O && !rd_map);
endmodule
bind aotr_top aotr_properties u_aotr_properties (.*);

// ---- sim/aotr_top_tb.sv ----
// testbench: register access, trim selection and access guards of the offset trim block
`timescale 1ns/10ps
module aotr_top_tb;
    import aotr_pkg::*;
    localparam logic [15:0] F1B = 16'h0123;
    localparam logic [15:0] F2A = 16'h0456;
    localparam logic [15:0] F2B = 16'h0789;
    logic MCLK_I, RESET_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
    logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, FG_CAL_START_O;
    logic FG_CAL_BUSY_I, FOREGROUND_CAL_COMPLETE_I, CALIBRATION_HALTED_I;
    logic CORE1_SAMPLES_B_I, CORE2_SAMPLES_B_I, CORE1_TRIM_VALID_O, CORE2_TRIM_VALID_O;
    logic KEEP_NEAR_DC_CONTENT_O, OFFSET_FILTER_ENABLE_O, BACKGROUND_CALIBRATION_ENABLE_O;
    logic BACKGROUND_OFFSET_CAL_ENABLE_O, OFFSET_CALIBRATION_ENABLE_O;
    logic [ADDR_W-1:0] AWADDR_I, ARADDR_I;
    logic [31:0] WDATA_I, RDATA_O, rd;
    logic [3:0] WSTRB_I;
    logic [1:0] BRESP_O, RRESP_O, rs;
    logic [TRIM_W-1:0] CORE1_TRIM_O, CORE2_TRIM_O;
    int num_errors, total_checks;
    aotr_top #(.FUSE_CORE1_IN_B(F1B), .FUSE_CORE2_IN_A(F2A), .FUSE_CORE2_IN_B(F2B)) u_aotr_top (.*);
    // free-running bench clock, 40 ns period
    initial
    begin
        MCLK_I = 1'b0;
        forever #20 MCLK_I = ~MCLK_I;
    end
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %0t: response %b expected %b", $time, got, exp);
        end
    endtask
    // a hung handshake ends the run rather than the whole simulation budget
    task automatic limit(input int n);
        if (n >= 50)
        begin
            num_errors++;
            $display("Error %0t: handshake timed out", $time);
            summarize();
        end
    endtask
    task automatic wr(input logic [11:0] ix, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic a, w, b;
        int n;
        n = 0;
        b = 1'b0;
        AWADDR_I <= {ix, 2'b00};
        WDATA_I <= d;
        WSTRB_I <= s;
        AWVALID_I <= 1'b1;
        WVALID_I <= 1'b1;
        while (!b && n < 50)
        begin
            @(negedge MCLK_I);
            a = AWVALID_I && AWREADY_O;
            w = WVALID_I && WREADY_O;
            b = BVALID_O;
            rs = BRESP_O;
            @(posedge MCLK_I);
            if (a) AWVALID_I <= 1'b0;
            if (w) WVALID_I <= 1'b0;
            n++;
        end
        // ready comes only once the answer stands, so the answer must hold a cycle
        BREADY_I <= 1'b1;
        @(posedge MCLK_I);
        BREADY_I <= 1'b0;
        limit(n);
        chk_resp(rs, er);
    endtask
    // read one word and compare the masked data and the response
    task automatic rdc(input logic [11:0] ix, input logic [31:0] e, input logic [31:0] m,
        input logic [1:0] er);
        logic a, r;
        int n;
        n = 0;
        r = 1'b0;
        ARADDR_I <= {ix, 2'b00};
        ARVALID_I <= 1'b1;
        while (!r && n < 50)
        begin
            @(negedge MCLK_I);
            a = ARVALID_I && ARREADY_O;
            r = RVALID_O;
            rd = RDATA_O;
            rs = RRESP_O;
            @(posedge MCLK_I);
            if (a) ARVALID_I <= 1'b0;
            n++;
        end
        RREADY_I <= 1'b1;
        @(posedge MCLK_I);
        RREADY_I <= 1'b0;
        limit(n);
        chk(rd & m, e);
        chk_resp(rs, er);
    endtask
    task automatic s_reset;
        rdc(IDX_TRIM_CORE1_IN_B, {16'h0, F1B}, 32'hffff_ffff, RESP_OKAY);
        rdc(IDX_TRIM_CORE2_IN_A, {16'h0, F2A}, 32'hffff_ffff, RESP_OKAY);
        rdc(IDX_TRIM_CORE2_IN_B, {16'h0, F2B}, 32'hffff_ffff, RESP_OKAY);
        rdc(IDX_OFFSET_FILTER_CTRL_ZERO, 32'h0, 32'hffff_ffff, RESP_OKAY);
        rdc(12'h098, 32'h0, 32'hffff_ffff, RESP_SLVERR);
        wr(12'h098, 32'h1, 4'hf, RESP_SLVERR);
    endtask
    // reserved nibble c rides along; trims have bit 11 set to expose sign handling
    task automatic s_rw;
        logic [11:0] ix [3];
        ix = '{IDX_TRIM_CORE1_IN_B, IDX_TRIM_CORE2_IN_A, IDX_TRIM_CORE2_IN_B};
        for (int i = 0; i < 3; i++)
        begin
            wr(ix[i], {16'hffff, 4'hc, 4'(8 + i), 8'ha1}, 4'hf, RESP_OKAY);
            rdc(ix[i], {16'h0, 4'hc, 4'(8 + i), 8'ha1}, 32'hffff_ffff, RESP_OKAY);
        end
        wr(IDX_TRIM_CORE1_IN_B, 32'h0000_0055, 4'h1, RESP_OKAY);
        rdc(IDX_TRIM_CORE1_IN_B, 32'h0000_c855, 32'hffff_ffff, RESP_OKAY);
    endtask
    task automatic s_core;
        CORE1_SAMPLES_B_I <= 1'b1;
        repeat (6) @(posedge MCLK_I);
        chk({31'h0, CORE1_TRIM_VALID_O}, 32'h1);
        chk({20'h0, CORE1_TRIM_O}, 32'h855);
        chk({20'h0, CORE2_TRIM_O}, 32'h9a1);
        chk({31'h0, CORE2_TRIM_VALID_O}, 32'h1);
        CORE2_SAMPLES_B_I <= 1'b1;
        CORE1_SAMPLES_B_I <= 1'b0;
        repeat (6) @(posedge MCLK_I);
        chk({20'h0, CORE2_TRIM_O}, 32'haa1);
        chk({31'h0, CORE1_TRIM_VALID_O}, 32'h0);
    endtask
    task automatic s_guard;
        FG_CAL_BUSY_I <= 1'b1;
        repeat (4) @(posedge MCLK_I);
        wr(IDX_TRIM_CORE2_IN_A, 32'h0000_0123, 4'hf, RESP_SLVERR);
        rdc(IDX_TRIM_CORE2_IN_A, 32'h0000_c9a1, 32'hffff_ffff, RESP_OKAY);
        rdc(IDX_ACCESS_STATUS, 32'h3, 32'h3, RESP_OKAY);
        FG_CAL_BUSY_I <= 1'b0;
        wr(IDX_CAL_CTRL, 32'h3, 4'hf, RESP_OKAY);
        chk({30'h0, BACKGROUND_CALIBRATION_ENABLE_O, BACKGROUND_OFFSET_CAL_ENABLE_O},
            32'h3);
        wr(IDX_TRIM_CORE2_IN_B, 32'h0000_0123, 4'hf, RESP_SLVERR);
        rdc(IDX_TRIM_CORE2_IN_B, 32'h0000_caa1, 32'hffff_ffff, RESP_OKAY);
        wr(IDX_CAL_CTRL, 32'h0, 4'hf, RESP_OKAY);
    endtask
    // each row: unused bit, done flag, halted flag, expected early-read flag; control word is 0x4 for rows 0-1, 0x3 after
    task automatic s_early;
        logic [3:0] t [4];
        t = '{4'b0100, 4'b0001, 4'b0001, 4'b0010};
        for (int i = 0; i < 4; i++)
        begin
            wr(IDX_ACCESS_STATUS, 32'h0, 4'hf, RESP_OKAY);
            wr(IDX_CAL_CTRL, (i < 2) ? 32'h4 : 32'h3, 4'hf, RESP_OKAY);
            FOREGROUND_CAL_COMPLETE_I <= t[i][2];
            CALIBRATION_HALTED_I <= t[i][1];
            repeat (4) @(posedge MCLK_I);
            rdc(IDX_TRIM_CORE1_IN_B, 32'h0000_c855, 32'hffff_ffff, RESP_OKAY);
            rdc(IDX_ACCESS_STATUS, {29'h0, t[i][0], 2'b00}, 32'h4, RESP_OKAY);
        end
        chk({31'h0, OFFSET_CALIBRATION_ENABLE_O}, 32'h0);
        rdc(IDX_CAL_STATUS, 32'h4, 32'h7, RESP_OKAY);
    endtask
    task automatic s_filter;
        wr(IDX_OFFSET_FILTER_CTRL_ZERO, 32'h1, 4'h1, RESP_OKAY);
        chk({31'h0, KEEP_NEAR_DC_CONTENT_O}, 32'h1);
        wr(IDX_CAL_CTRL, 32'h18, 4'hf, RESP_OKAY);
        chk({30'h0, OFFSET_FILTER_ENABLE_O, FG_CAL_START_O}, 32'h3);
        wr(IDX_OFFSET_FILTER_CTRL_ZERO, 32'h0, 4'h1, RESP_OKAY);
        chk({31'h0, KEEP_NEAR_DC_CONTENT_O}, 32'h0);
    endtask
    // main sequence: reset for two cycles, then each scenario in turn
    initial
    begin
        num_errors = 0;
        total_checks = 0;
        {RESET_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = 6'h20;
        {FG_CAL_BUSY_I, FOREGROUND_CAL_COMPLETE_I, CALIBRATION_HALTED_I} = 3'h0;
        {CORE1_SAMPLES_B_I, CORE2_SAMPLES_B_I, WSTRB_I} = 6'h0;
        {AWADDR_I, ARADDR_I, WDATA_I} = '0;
        repeat (2) @(posedge MCLK_I);
        RESET_I <= 1'b0;
        repeat (2) @(posedge MCLK_I);
        s_reset();
        s_rw();
        s_core();
        s_guard();
        s_early();
        s_filter();
        summarize();
    end
endmodule
